// ### design/tsc_cfg.svh
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// Device register offsets
`define TSC_OFF_CFG0      8'h01
`define TSC_OFF_HI_UPPER  8'h02
`define TSC_OFF_HI_LOWER  8'h03
`define TSC_OFF_LO_UPPER  8'h04
`define TSC_OFF_LO_LOWER  8'h05
`define TSC_OFF_FAPPLY    8'h06
`define TSC_OFF_SOFT_DATA 8'h07
`define TSC_OFF_SOFT_EN   8'h08
`define TSC_OFF_PIN_FUNC  8'h09
`define TSC_OFF_STATUS    8'h0c
`define TSC_REG_FIRST     1
`define TSC_REG_LAST      9

// Field positions
`define TSC_CAP_MSB       4
`define TSC_CAP_LSB       0
`define TSC_CKDIV_TOP     7
`define TSC_CKDIV_MSB     6
`define TSC_CKDIV_LSB     5
`define TSC_CKDIV_MAX_TAP 3'h4
`define TSC_INT_MSB       15
`define TSC_INT_LSB       12
`define TSC_FRAC_MSB      11
`define TSC_FRAC_LSB      0
`define TSC_PIN_FUNC_MASK 8'h07
`define TSC_BIT0_MASK     8'h01

// Values
`define TSC_RST_BYTE      8'h00
`define TSC_RST_WORD      16'h0000
`define TSC_FRAC_ZERO     12'h000
`define TSC_INT_OFFSET    5'h10
`define TSC_DIV_MIN       16'h2f42
`define TSC_DIV_MAX       16'hc05a

// Host controller's own register offsets
`define TSC_H_OFF_ADDR    8'h00
`define TSC_H_OFF_WDATA   8'h01
`define TSC_H_OFF_CMD     8'h02
`define TSC_H_OFF_STATUS  8'h03
`define TSC_H_OFF_RDATA   8'h04
`define TSC_H_OFF_CTRL    8'h05

`endif

// ### design/tsc_device_end.sv
// Overview of operation
// - Config byte: capacitor low five, divider top three
// - Divider codes 0-3 give 2-16, 1XX gives 32
// - High-tone word from upper and lower bytes
// - Top nibble integer, low twelve bits fraction
// - Low-tone word sets low tone or carrier
// - Host keeps divider words inside valid range
// - Sixteen added to integer part internally
// - Zero fractions stop the delta-sigma modulator
// - Host may pick wide bandwidth when integer-only
// - Apply bit copies divider bytes to active
// - Apply bit clears itself after the update
// - Soft data bit mirrors the data pin
// - Host holds unused data source low
// - Soft enable bit mirrors the enable pin
// - Host holds unused enable source low
// - Pin function in bits 2-0, rest zero
// - Pin function codes select the output source
// - Status top nibble shows current integer nibble
`timescale 1ns/1ps
`include "tsc_cfg.svh"
`default_nettype none

module tsc_device_end
    import tsc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    tsc_link_if.dev          link,
    input  wire logic        mode_fsk_in,
    input  wire logic        clk_out_gate_in,
    input  wire logic        cs_n_in,
    input  wire logic        sdo_in,
    input  wire logic        osc_stopped_in,
    input  wire logic        synth_locked_in,
    output logic [4:0]       cap_level_out,
    output logic             clock_out,
    output logic             general_output_pin_out,
    output logic [15:0]      active_hi_div_out,
    output logic [15:0]      active_lo_div_out,
    output logic [16:0]      synth_div_out,
    output logic             frac_mod_on_out,
    output logic             tx_data_out,
    output logic             tx_enable_out
);

    localparam int PIN_LOCK = 0;
    localparam int PIN_OSC  = 1;
    localparam int PIN_SDO  = 2;
    localparam int PIN_CSN  = 3;
    localparam int PIN_EN   = 4;
    localparam int PIN_DIN  = 5;

    tsc_dev_state_t q;
    tsc_dev_state_t next_q;

    logic [5:0]  pins_raw;
    logic        eff_data;
    logic        eff_en;
    logic [2:0]  ck_tap;
    logic        ck_div;
    logic [15:0] sel_word;
    logic [3:0]  status_nib;
    logic [7:0]  status_byte;
    tsc_pin_fn_t pin_func;

    assign pins_raw = {link.din, link.enable, cs_n_in, sdo_in, osc_stopped_in, synth_locked_in};

    always_comb begin
        next_q = q;

        // Pins come from outside the clock domain
        next_q.sync1 = pins_raw;
        next_q.sync2 = q.sync1;

        eff_data = q.sync2[PIN_DIN] | q.bank[`TSC_OFF_SOFT_DATA][0];
        eff_en   = q.sync2[PIN_EN] | q.bank[`TSC_OFF_SOFT_EN][0];

        // Free-running divider; tap 0 is clk_in divided by two
        next_q.div_cnt = q.div_cnt + 5'h01;
        ck_tap = q.bank[`TSC_OFF_CFG0][`TSC_CKDIV_TOP] ? `TSC_CKDIV_MAX_TAP :
                 {1'b0, q.bank[`TSC_OFF_CFG0][`TSC_CKDIV_MSB:`TSC_CKDIV_LSB]};
        ck_div = q.div_cnt[ck_tap];

        // FSK picks tone by data, ASK always runs on the low-tone word
        sel_word = (mode_fsk_in && eff_data) ? q.act_hi : q.act_lo;
        status_nib = sel_word[`TSC_INT_MSB:`TSC_INT_LSB];
        status_byte = {status_nib, 2'b00, q.sync2[PIN_LOCK], q.sync2[PIN_OSC]};

        // Apply strobe: transfer and self-clear on the same edge
        if (q.bank[`TSC_OFF_FAPPLY][0]) begin
            next_q.act_hi = {q.bank[`TSC_OFF_HI_UPPER], q.bank[`TSC_OFF_HI_LOWER]};
            next_q.act_lo = {q.bank[`TSC_OFF_LO_UPPER], q.bank[`TSC_OFF_LO_LOWER]};
            next_q.bank[`TSC_OFF_FAPPLY] = `TSC_RST_BYTE;
        end

        // A new write lands after the self-clear so it is never lost
        for (int i = `TSC_REG_FIRST; i <= `TSC_REG_LAST; i++) begin
            if (link.wr && link.addr == 8'(i)) begin
                if (8'(i) == `TSC_OFF_FAPPLY) begin
                    next_q.bank[i] = link.wdata & `TSC_BIT0_MASK;
                end else begin
                    next_q.bank[i] = link.wdata;
                end
            end
        end

        // Read data stand the cycle after the strobe, zero when idle
        next_q.rdata = `TSC_RST_BYTE;
        if (link.rd) begin
            if (link.addr == `TSC_OFF_STATUS) begin
                next_q.rdata = status_byte;
            end else if (link.addr >= 8'(`TSC_REG_FIRST) &&
                         link.addr <= 8'(`TSC_REG_LAST)) begin
                next_q.rdata = q.bank[link.addr[3:0]];
            end
        end

        // Integer part carries the fixed offset inside the synthesizer
        next_q.synth_div = {(5'(sel_word[`TSC_INT_MSB:`TSC_INT_LSB]) + `TSC_INT_OFFSET),
                            sel_word[`TSC_FRAC_MSB:`TSC_FRAC_LSB]};
        next_q.frac_on = (q.act_hi[`TSC_FRAC_MSB:`TSC_FRAC_LSB] != `TSC_FRAC_ZERO) ||
                         (q.act_lo[`TSC_FRAC_MSB:`TSC_FRAC_LSB] != `TSC_FRAC_ZERO);
        next_q.cap = q.bank[`TSC_OFF_CFG0][`TSC_CAP_MSB:`TSC_CAP_LSB];
        next_q.clk_out = ck_div;
        next_q.tx_data = eff_data;
        next_q.tx_en = eff_en;

        // Reserved pin codes drive low
        pin_func = tsc_pin_fn_t'(q.bank[`TSC_OFF_PIN_FUNC][2:0]);
        unique case (pin_func)
            TSC_PF_CLK_SDO: next_q.pin_out = q.sync2[PIN_CSN] ? (clk_out_gate_in & ck_div)
                                                             : q.sync2[PIN_SDO];
            TSC_PF_SDO:     next_q.pin_out = q.sync2[PIN_SDO];
            TSC_PF_CLK:     next_q.pin_out = ck_div;
            TSC_PF_RSV3:    next_q.pin_out = 1'b0;
            TSC_PF_RSV4:    next_q.pin_out = 1'b0;
            TSC_PF_NOOSC:   next_q.pin_out = q.sync2[PIN_OSC];
            TSC_PF_READY:   next_q.pin_out = q.sync2[PIN_LOCK];
            TSC_PF_DATA:    next_q.pin_out = q.bank[`TSC_OFF_SOFT_DATA][0];
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign link.rdata             = q.rdata;
    assign cap_level_out          = q.cap;
    assign clock_out              = q.clk_out;
    assign general_output_pin_out = q.pin_out;
    assign active_hi_div_out      = q.act_hi;
    assign active_lo_div_out      = q.act_lo;
    assign synth_div_out          = q.synth_div;
    assign frac_mod_on_out        = q.frac_on;
    assign tx_data_out            = q.tx_data;
    assign tx_enable_out          = q.tx_en;

endmodule : tsc_device_end

`default_nettype wire

// ### design/tsc_host_end.sv
`timescale 1ns/1ps
`include "tsc_cfg.svh"
`default_nettype none

module tsc_host_end
    import tsc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    tsc_link_if.host         link,
    input  wire logic [7:0]  sw_addr_in,
    input  wire logic [7:0]  sw_wdata_in,
    input  wire logic        sw_wr_in,
    input  wire logic        sw_rd_in,
    input  wire logic        tx_data_in,
    input  wire logic        tx_enable_in,
    output logic [7:0]       sw_rdata_out,
    output logic             pll_wide_bw_out
);

    tsc_host_state_t q;
    tsc_host_state_t next_q;

    logic       busy;
    logic [7:0] wd;
    logic       bad_range;

    always_comb begin
        next_q = q;
        busy = (q.fsm != TSC_H_IDLE);
        wd = q.h_wdata;
        bad_range = (q.hi_word < `TSC_DIV_MIN) || (q.hi_word > `TSC_DIV_MAX) ||
                    (q.lo_word < `TSC_DIV_MIN) || (q.lo_word > `TSC_DIV_MAX);

        // Unused source of data and enable is held low
        if (q.h_addr == `TSC_OFF_SOFT_DATA) begin
            wd = q.soft_data ? (q.h_wdata & `TSC_BIT0_MASK) : `TSC_RST_BYTE;
        end else if (q.h_addr == `TSC_OFF_SOFT_EN) begin
            wd = q.soft_en ? (q.h_wdata & `TSC_BIT0_MASK) : `TSC_RST_BYTE;
        end else if (q.h_addr == `TSC_OFF_PIN_FUNC) begin
            wd = q.h_wdata & `TSC_PIN_FUNC_MASK;
        end
        next_q.din_pin = q.soft_data ? 1'b0 : tx_data_in;
        next_q.en_pin  = q.soft_en ? 1'b0 : tx_enable_in;
        next_q.wide_bw = (q.hi_word[`TSC_FRAC_MSB:`TSC_FRAC_LSB] == `TSC_FRAC_ZERO) &&
                         (q.lo_word[`TSC_FRAC_MSB:`TSC_FRAC_LSB] == `TSC_FRAC_ZERO);

        next_q.link_wr = 1'b0;
        next_q.link_rd = 1'b0;

        // Software port
        next_q.sw_rdata = `TSC_RST_BYTE;
        if (sw_rd_in) begin
            if (sw_addr_in == `TSC_H_OFF_ADDR) begin
                next_q.sw_rdata = q.h_addr;
            end else if (sw_addr_in == `TSC_H_OFF_WDATA) begin
                next_q.sw_rdata = q.h_wdata;
            end else if (sw_addr_in == `TSC_H_OFF_STATUS) begin
                next_q.sw_rdata = {5'h00, q.refused, q.rdone, busy};
            end else if (sw_addr_in == `TSC_H_OFF_RDATA) begin
                next_q.sw_rdata = q.link_rdata;
            end else if (sw_addr_in == `TSC_H_OFF_CTRL) begin
                next_q.sw_rdata = {6'h00, q.soft_en, q.soft_data};
            end
        end
        if (sw_wr_in) begin
            if (sw_addr_in == `TSC_H_OFF_ADDR) begin
                next_q.h_addr = sw_wdata_in;
            end else if (sw_addr_in == `TSC_H_OFF_WDATA) begin
                next_q.h_wdata = sw_wdata_in;
            end else if (sw_addr_in == `TSC_H_OFF_CTRL) begin
                next_q.soft_data = sw_wdata_in[0];
                next_q.soft_en   = sw_wdata_in[1];
            end
        end

        unique case (q.fsm)
            TSC_H_IDLE: begin
                // Commands arriving while busy are dropped
                if (sw_wr_in && sw_addr_in == `TSC_H_OFF_CMD &&
                    (sw_wdata_in[0] || sw_wdata_in[1])) begin
                    next_q.rdone = 1'b0;
                    next_q.refused = 1'b0;
                    next_q.link_addr = q.h_addr;
                    next_q.link_wdata = wd;
                    if (sw_wdata_in[1]) begin
                        next_q.link_rd = 1'b1;
                        next_q.fsm = TSC_H_ISSUE;
                    end else if (q.h_addr == `TSC_OFF_FAPPLY && wd[0] && bad_range) begin
                        next_q.refused = 1'b1;
                    end else begin
                        next_q.link_wr = 1'b1;
                        next_q.fsm = TSC_H_ISSUE;
                        if (q.h_addr == `TSC_OFF_HI_UPPER) next_q.hi_word[15:8] = wd;
                        if (q.h_addr == `TSC_OFF_HI_LOWER) next_q.hi_word[7:0] = wd;
                        if (q.h_addr == `TSC_OFF_LO_UPPER) next_q.lo_word[15:8] = wd;
                        if (q.h_addr == `TSC_OFF_LO_LOWER) next_q.lo_word[7:0] = wd;
                    end
                end
            end
            TSC_H_ISSUE: begin
                next_q.fsm = TSC_H_CAPT;
            end
            TSC_H_CAPT: begin
                next_q.link_rdata = link.rdata;
                next_q.rdone = 1'b1;
                next_q.fsm = TSC_H_IDLE;
            end
            default: begin
                next_q.fsm = TSC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.fsm <= TSC_H_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign link.addr       = q.link_addr;
    assign link.wdata      = q.link_wdata;
    assign link.wr         = q.link_wr;
    assign link.rd         = q.link_rd;
    assign link.din        = q.din_pin;
    assign link.enable     = q.en_pin;
    assign sw_rdata_out    = q.sw_rdata;
    assign pll_wide_bw_out = q.wide_bw;

endmodule : tsc_host_end

`default_nettype wire

// ### design/tsc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tsc_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       din;
    logic       enable;

    modport dev (input addr, wdata, wr, rd, din, enable, output rdata);
    modport host (output addr, wdata, wr, rd, din, enable, input rdata);
endinterface : tsc_link_if

`default_nettype wire

// ### design/tsc_pkg.sv
`default_nettype none

package tsc_pkg;

    typedef enum logic [2:0] {
        TSC_PF_CLK_SDO = 3'h0,
        TSC_PF_SDO     = 3'h1,
        TSC_PF_CLK     = 3'h2,
        TSC_PF_RSV3    = 3'h3,
        TSC_PF_RSV4    = 3'h4,
        TSC_PF_NOOSC   = 3'h5,
        TSC_PF_READY   = 3'h6,
        TSC_PF_DATA    = 3'h7
    } tsc_pin_fn_t;

    typedef struct packed {
        logic [9:1][7:0] bank;
        logic [15:0]     act_hi;
        logic [15:0]     act_lo;
        logic [5:0]      sync1;
        logic [5:0]      sync2;
        logic [4:0]      div_cnt;
        logic [7:0]      rdata;
        logic [16:0]     synth_div;
        logic [4:0]      cap;
        logic            frac_on;
        logic            tx_data;
        logic            tx_en;
        logic            clk_out;
        logic            pin_out;
    } tsc_dev_state_t;

    typedef enum logic [2:0] {
        TSC_H_IDLE  = 3'b001,
        TSC_H_ISSUE = 3'b010,
        TSC_H_CAPT  = 3'b100
    } tsc_host_fsm_t;

    typedef struct packed {
        tsc_host_fsm_t fsm;
        logic [7:0]    h_addr;
        logic [7:0]    h_wdata;
        logic [7:0]    link_rdata;
        logic [7:0]    sw_rdata;
        logic [15:0]   hi_word;
        logic [15:0]   lo_word;
        logic [7:0]    link_addr;
        logic [7:0]    link_wdata;
        logic          link_wr;
        logic          link_rd;
        logic          soft_data;
        logic          soft_en;
        logic          refused;
        logic          rdone;
        logic          din_pin;
        logic          en_pin;
        logic          wide_bw;
    } tsc_host_state_t;

endpackage : tsc_pkg

`default_nettype wire

// ### test/tsc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none

module tsc_link_chk
    import tsc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       din,
    input  wire logic       enable
);
    // Mirror of every byte written over the link to offsets 01-09, so reads can be judged without the device
    logic [9:1][7:0] sh;
    logic [7:0]      exp_rd;
    logic [15:0]     hi_w;
    logic [15:0]     lo_w;
    logic            mapped;

    assign hi_w   = {sh[2], sh[3]};
    assign lo_w   = {sh[4], sh[5]};
    assign mapped = addr inside {[8'h01:8'h05], [8'h07:8'h09]};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sh     <= '0;
            exp_rd <= 8'h00;
        end else begin
            if (wr && addr >= 8'h01 && addr <= 8'h09) begin
                sh[addr[3:0]] <= wdata;
            end
            if (rd && mapped) begin
                exp_rd <= sh[addr[3:0]];
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    strobe_excl_a: assert property (!(wr && rd))
        else $error("write and read strobes together");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    readback_a: assert property (rd && mapped |=> rdata == exp_rd)
        else $error("read data differs from last byte written");
    apply_clear_a: assert property (rd && addr == 8'h06 |=> rdata == 8'h00)
        else $error("apply bit did not clear itself");
    unmapped_rd_a: assert property (rd && !mapped && addr != 8'h06 && addr != 8'h0c
        |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    status_rsv_a: assert property (rd && addr == 8'h0c |=> rdata[3:2] == 2'b00)
        else $error("status reserved bits not zero");
    div_range_a: assert property (wr && addr == 8'h06 && wdata[0] |-> hi_w >= 16'h2f42
        && hi_w <= 16'hc05a && lo_w >= 16'h2f42 && lo_w <= 16'hc05a)
        else $error("apply sent with divider word out of range");
    pin_rsv_a: assert property (wr && addr == 8'h09 |-> wdata[7:3] == 5'h00)
        else $error("pin function reserved bits set");
    din_quiet_a: assert property (wr && addr == 8'h07 && wdata[0] |-> !din)
        else $error("data pin high while soft data used");
    en_quiet_a: assert property (wr && addr == 8'h08 && wdata[0] |-> !enable)
        else $error("enable pin high while soft enable used");

    apply_c: cover property (wr && addr == 8'h06 && wdata[0]);
    status_c: cover property (rd && addr == 8'h0c);
    unmapped_c: cover property (rd && addr == 8'h0a);
    readback_c: cover property (rd && mapped ##1 rdata != 8'h00);
endmodule : tsc_link_chk

`default_nettype wire

// ### test/tx_synth_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module tx_synth_config_regs_test
    import tsc_pkg::*;
;
    logic        clk_in, rst_n_in, mode_fsk, clk_gate, cs_n, sdo, osc_stopped, locked;
    logic [7:0]  sw_addr, sw_wdata, sw_rdata, s;
    logic        sw_wr, sw_rd, tx_data, tx_enable, wide_bw;
    logic [4:0]  cap;
    logic        clock_o, pin_o, frac_on, tx_data_o, tx_en_o, p;
    logic [15:0] act_hi, act_lo;
    logic [16:0] synth_div;
    int          err_total, checks, cyc, n;
    logic [7:0]  pin_exp;

    tsc_link_if tsc_link_if_i ();
    tsc_device_end tsc_device_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(tsc_link_if_i),
        .mode_fsk_in(mode_fsk), .clk_out_gate_in(clk_gate), .cs_n_in(cs_n), .sdo_in(sdo),
        .osc_stopped_in(osc_stopped), .synth_locked_in(locked), .cap_level_out(cap),
        .clock_out(clock_o), .general_output_pin_out(pin_o), .active_hi_div_out(act_hi),
        .active_lo_div_out(act_lo), .synth_div_out(synth_div), .frac_mod_on_out(frac_on),
        .tx_data_out(tx_data_o), .tx_enable_out(tx_en_o));
    tsc_host_end tsc_host_end_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(tsc_link_if_i),
        .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
        .tx_data_in(tx_data), .tx_enable_in(tx_enable), .sw_rdata_out(sw_rdata),
        .pll_wide_bw_out(wide_bw));
    tsc_link_chk tsc_link_chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .addr(tsc_link_if_i.addr), .wdata(tsc_link_if_i.wdata), .wr(tsc_link_if_i.wr),
        .rd(tsc_link_if_i.rd), .rdata(tsc_link_if_i.rdata), .din(tsc_link_if_i.din),
        .enable(tsc_link_if_i.enable));

    task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sw_wr    <= 1'b1;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge clk_in);
        sw_wr <= 1'b0;
    endtask : sw_write

    // Read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        sw_rd   <= 1'b1;
        sw_addr <= a;
        @(posedge clk_in);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask : sw_read

    task automatic wait_idle();
        logic [7:0] st;
        int         k;
        st = 8'h01;
        k  = 0;
        while (st[0] === 1'b1 && k < 10) begin
            sw_read(8'h03, st);
            k++;
        end
        check(st[0], 1'b0, "busy");
    endtask : wait_idle

    task automatic dev_write(input logic [7:0] a, input logic [7:0] d);
        sw_write(8'h00, a);
        sw_write(8'h01, d);
        sw_write(8'h02, 8'h01);
        wait_idle();
    endtask : dev_write

    task automatic dev_expect(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        sw_write(8'h00, a);
        sw_write(8'h02, 8'h02);
        wait_idle();
        sw_read(8'h04, v);
        check(v, exp, what);
    endtask : dev_expect

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Ceiling is more than ten times the expected run, so a hang is cut short
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {rst_n_in, mode_fsk, clk_gate, cs_n, sdo, osc_stopped, locked} = '0;
        {sw_addr, sw_wdata, sw_wr, sw_rd, tx_data, tx_enable} = '0;
        {err_total, checks, cyc} = '0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int a = 0; a < 14; a++) dev_expect(a[7:0], 8'h00, "reset value");
        check(wide_bw, 1'b1, "wide bw at reset");
        $display("reset test done");

        for (int c = 0; c < 8; c++) begin
            dev_write(8'h01, {c[2:0], 5'h15});
            check(cap, 5'h15, "cap level");
            dev_expect(8'h01, {c[2:0], 5'h15}, "config readback");
            n = 0;
            p = clock_o;
            repeat (64) begin
                @(posedge clk_in);
                #1;
                if (clock_o && !p) n++;
                p = clock_o;
            end
            check(n, c[2] ? 2 : 32 >> c, "clock edges");
        end
        $display("clock divider test done");

        dev_write(8'h02, 8'h5a);
        dev_write(8'h03, 8'h3c);
        dev_write(8'h04, 8'h30);
        dev_write(8'h05, 8'h00);
        check(act_hi, 16'h0000, "hi before apply");
        @(posedge clk_in);
        mode_fsk <= 1'b1;
        tx_data  <= 1'b1;
        dev_write(8'h06, 8'h01);
        check(act_hi, 16'h5a3c, "hi word");
        check(act_lo, 16'h3000, "lo word");
        dev_expect(8'h06, 8'h00, "apply bit");
        check(frac_on, 1'b1, "modulator on");
        check(wide_bw, 1'b0, "wide bw off");
        check(synth_div, {5'h15, 12'ha3c}, "fsk high");
        dev_expect(8'h0c, 8'h50, "status fsk high");
        @(posedge clk_in);
        tx_data <= 1'b0;
        dev_expect(8'h0c, 8'h30, "status fsk low");
        check(synth_div, {5'h13, 12'h000}, "fsk low");
        @(posedge clk_in);
        mode_fsk <= 1'b0;
        tx_data  <= 1'b1;
        dev_expect(8'h0c, 8'h30, "status ask");
        check(synth_div, {5'h13, 12'h000}, "ask carrier");
        dev_write(8'h03, 8'h00);
        dev_write(8'h02, 8'h50);
        dev_write(8'h06, 8'h01);
        check(frac_on, 1'b0, "integer only");
        check(wide_bw, 1'b1, "wide bw on");
        dev_write(8'h02, 8'h2f);
        dev_write(8'h03, 8'h42);
        dev_write(8'h04, 8'hc0);
        dev_write(8'h05, 8'h5a);
        dev_write(8'h06, 8'h01);
        sw_read(8'h03, s);
        check(s[2], 1'b0, "limits accepted");
        check(act_hi, 16'h2f42, "limit hi word");
        check(act_lo, 16'hc05a, "limit lo word");
        dev_write(8'h03, 8'h41);
        dev_write(8'h06, 8'h01);
        sw_read(8'h03, s);
        check(s[2], 1'b1, "below limit refused");
        check(act_hi, 16'h2f42, "hi kept");
        $display("divider test done");

        @(posedge clk_in);
        tx_data   <= 1'b0;
        tx_enable <= 1'b1;
        dev_expect(8'h08, 8'h00, "soft enable idle");
        check(tx_en_o, 1'b1, "enable pin");
        @(posedge clk_in);
        tx_enable <= 1'b0;
        sw_write(8'h05, 8'h03);
        sw_read(8'h05, s);
        check(s, 8'h03, "soft modes");
        dev_write(8'h07, 8'h01);
        dev_write(8'h08, 8'h01);
        check(tx_data_o, 1'b1, "soft data");
        check(tx_en_o, 1'b1, "soft enable");
        @(posedge clk_in);
        osc_stopped <= 1'b1;
        sdo         <= 1'b1;
        pin_exp = 8'b1010_0011;
        for (int c = 0; c < 8; c++) begin
            dev_write(8'h09, c[7:0]);
            if (c != 2) check(pin_o, pin_exp[c], "pin function");
        end
        @(posedge clk_in);
        cs_n   <= 1'b1;
        locked <= 1'b1;
        dev_write(8'h09, 8'h06);
        check(pin_o, 1'b1, "ready pin");
        dev_write(8'h09, 8'h00);
        check(pin_o, 1'b0, "clock gated with select high");
        @(posedge clk_in);
        clk_gate <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        n = 0;
        p = pin_o;
        repeat (64) begin
            @(posedge clk_in);
            #1;
            if (pin_o && !p) n++;
            p = pin_o;
        end
        check(n, 2, "clock with select high");
        dev_write(8'h09, 8'hfd);
        dev_expect(8'h09, 8'h05, "reserved bits");
        dev_expect(8'h0c, 8'hc3, "status ask flags");
        $display("pin test done");
        close_out();
    end
endmodule : tx_synth_config_regs_test

`default_nettype wire
